// file: byte_queue.sv
// Byte-wide sample queue with overwrite of the oldest byte when pushed while full.
`timescale 1ns/1ps
module byte_queue #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Write side.
  input wire logic push,
  input wire logic [7:0] push_data,
  // Read side.
  input wire logic pop,
  output logic [7:0] head,
  output logic [AW:0] count,
  output logic full,
  output logic empty
);
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  wire do_pop = (pop && !empty) || (push && full && !pop);
  wire do_push = push;
  // Pushing into a full queue drops the oldest byte, so the count stays put.
  wire [AW:0] nxt_count = count_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);

  assign head = mem[rd_ptr_ff];
  assign count = count_ff;
  assign full = count_ff == (AW+1)'(DEPTH);
  assign empty = count_ff == '0;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= do_push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
      rd_ptr_ff <= do_pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
      count_ff <= nxt_count;
    end
  end
endmodule

// file: meas_source.sv
// Measurement core stand-in that hands finished results to the sensor registers.
`timescale 1ns/1ps
module meas_source (
  // Clock.
  input wire logic clk,
  // Request from the bench.
  input wire logic fire,
  input wire logic [23:0] base,
  // Results towards the device.
  output logic meas_done,
  output logic [23:0] press_unfilt,
  output logic [23:0] press_filt,
  output logic [23:0] temp_unfilt,
  output logic [23:0] temp_filt,
  output logic [23:0] sensor_time
);
  initial begin
    meas_done = 1'b0;
    press_unfilt = 24'h0;
    press_filt = 24'h0;
    temp_unfilt = 24'h0;
    temp_filt = 24'h0;
    sensor_time = 24'h0;
  end
  // Results are only good with the done pulse; otherwise they flip each cycle,
  // so a design that samples them late gets garbage.
  always @(posedge clk) begin
    meas_done <= fire;
    sensor_time <= sensor_time + 24'h1;
    if (fire) begin
      press_unfilt <= base;
      press_filt <= ~base;
      temp_unfilt <= base + 24'h1;
      temp_filt <= ~(base + 24'h1);
    end else begin
      press_unfilt <= ~press_unfilt;
      press_filt <= ~press_filt;
      temp_unfilt <= ~temp_unfilt;
      temp_filt <= ~temp_filt;
    end
  end
endmodule

// file: sensor_cfg_regs.sv
// Configuration and status registers, sample queue front end and interrupt pin of the sensor.
//
// Operation
// - Queue fill count: low byte at 0x12, upper bits at 0x13.
// - Reading 0x14 returns the next queued byte and removes it.
// - Nine-bit watermark: bits 7..0 at 0x15, bit 8 at 0x16.
// - Samples enter the queue only while the queue enable bit is set.
// - Stop-on-full set halts storing when full; clear keeps writing.
// - Time-frame bit set returns a sensor-time frame after the last data frame.
// - Pressure stored only when bit 3 set, temperature only when bit 4 set.
// - Stored samples are decimated by two to the subsampling field.
// - Source code 1 picks filtered data; codes 0, 2, 3 pick unfiltered.
// - Interrupt control bit 0 selects push-pull (0) or open-drain (1).
// - Interrupt control bit 1 selects active low (0) or high (1).
// - Interrupt control bit 2 enables latching of watermark and full in pin and status; data ready always latches until read.
// - Watermark interrupt reported only while bit 3 is set.
// - Queue-full interrupt reported only while bit 4 is set.
// - Data-ready interrupt reported only while bit 6 is set.
// - Serial setup bit 0 selects four-wire (0) or three-wire (1) port.
// - Watchdog runs only while serial setup bit 1 is set; kept non-volatile.
// - Watchdog times out after 1.25 ms (bit 2 clear) or 40 ms.
// - Pressure measured only while power bit 0 is set.
// - Temperature measured only while power bit 1 is set.
// - Mode field: 00 sleep, 01 or 10 forced, 11 normal.
// - Oversampling: pressure bits 2:0, temperature bits 5:3, codes x1 to x32.
// - Status: watermark bit 0, full bit 1, data ready bit 3; clear on read.
`timescale 1ns/1ps
module sensor_cfg_regs
  import sensor_regs_pkg::*;
#(
  parameter int WDT_SHORT_CYCLES = WDT_SHORT_CYC,
  parameter int WDT_LONG_CYCLES = WDT_LONG_CYC,
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int AW = 9
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port from the serial engines.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Measurement results.
  input wire logic meas_done,
  input wire logic [23:0] press_unfilt,
  input wire logic [23:0] press_filt,
  input wire logic [23:0] temp_unfilt,
  input wire logic [23:0] temp_filt,
  input wire logic [23:0] sensor_time,
  // Non-volatile watchdog settings and serial activity.
  input wire logic nvm_wdt_en,
  input wire logic nvm_wdt_long,
  input wire logic i2c_busy,
  // Measurement control.
  output logic press_meas_en,
  output logic temp_meas_en,
  output meas_mode_t meas_mode,
  output logic [2:0] press_oversample_ratio,
  output logic [2:0] temperature_oversample_ratio,
  // Serial port control.
  output logic three_wire_serial_select,
  output logic i2c_wdt_enable,
  output logic i2c_wdt_long,
  output logic i2c_wdt_expire,
  // Interrupt pin.
  output logic int_pin_out,
  output logic int_pin_oe_n
);
  logic [7:0] reg_rdata_ff;
  logic [8:0] wtm_ff;
  logic [7:0] content_ff;
  logic [7:0] sampling_ff;
  logic [7:0] irq_setup_ff;
  logic [7:0] serial_ff;
  logic [7:0] power_ff;
  logic [7:0] oversample_ff;
  logic [7:0] status_ff;
  logic nvm_loaded_ff;
  logic [6:0] sub_cnt_ff;
  logic [55:0] frame_ff;
  logic [2:0] frame_left_ff;
  logic [2:0] time_idx_ff;
  logic [23:0] time_snap_ff;
  logic [21:0] wdt_cnt_ff;
  logic i2c_wdt_expire_ff;
  logic int_pin_out_ff;
  logic int_pin_oe_n_ff;
  meas_mode_t meas_mode_ff;
  logic [7:0] q_head;
  logic [AW:0] q_count;
  logic q_full;
  logic q_empty;

  // Register port decode.
  wire wr_wtm_lo = reg_wr && reg_addr == ADDR_WTM_LO;
  wire wr_wtm_hi = reg_wr && reg_addr == ADDR_WTM_HI;
  wire wr_content = reg_wr && reg_addr == ADDR_CONTENT;
  wire wr_sampling = reg_wr && reg_addr == ADDR_SAMPLING;
  wire wr_irq = reg_wr && reg_addr == ADDR_IRQ_SETUP;
  wire wr_serial = reg_wr && reg_addr == ADDR_SERIAL;
  wire wr_power = reg_wr && reg_addr == ADDR_POWER;
  wire wr_osr = reg_wr && reg_addr == ADDR_OVERSAMPLE;
  wire rd_port = reg_rd && reg_addr == ADDR_READ_PORT;
  wire rd_status = reg_rd && reg_addr == ADDR_IRQ_STATUS;

  // Queue content setup.
  wire q_enable = content_ff[CT_ENABLE];
  wire stop_full = content_ff[CT_STOP_FULL];
  wire time_en = content_ff[CT_TIME_EN];
  wire store_press = content_ff[CT_PRESS_EN];
  wire store_temp = content_ff[CT_TEMP_EN];
  wire [2:0] sub_sel = sampling_ff[SS_SUB_LSB +: 3];
  wire use_filt = sampling_ff[SS_SRC_LSB +: 2] == SRC_FILTERED;
  wire [23:0] press_src = use_filt ? press_filt : press_unfilt;
  wire [23:0] temp_src = use_filt ? temp_filt : temp_unfilt;

  // Decimation keeps one sample in every 2^sub_sel conversions.
  wire [6:0] sub_mask = 7'((8'h01 << sub_sel) - 8'h01);
  wire sub_hit = (sub_cnt_ff & sub_mask) == 7'h00;
  wire any_content = store_press || store_temp;
  wire blocked = stop_full && q_full;
  // A conversion that lands while a frame is still being pushed is skipped.
  wire store_ev = meas_done && q_enable && any_content && sub_hit &&
                  frame_left_ff == 3'h0 && !blocked;
  wire [7:0] hdr = HDR_DATA | (content_ff & HDR_CONTENT_MASK);
  wire [55:0] frame_new = store_press ? {temp_src, press_src, hdr}
                                      : {24'h000000, temp_src, hdr};
  wire [2:0] len_new = 3'h1 + (store_press ? 3'h3 : 3'h0) + (store_temp ? 3'h3 : 3'h0);
  wire q_push = frame_left_ff != 3'h0 && q_enable && !blocked;
  wire q_pop = rd_port && !q_empty;

  // Time frame follows the last data byte while the queue is drained.
  wire time_phase = time_en && q_empty && time_idx_ff < TIME_FRAME_LEN;
  wire [7:0] time_byte = time_idx_ff == 3'h0 ? HDR_TIME
                       : time_idx_ff == 3'h1 ? sensor_time[7:0]
                       : time_idx_ff == 3'h2 ? time_snap_ff[15:8]
                       : time_snap_ff[23:16];
  wire [7:0] port_byte = !q_empty ? q_head : time_phase ? time_byte : EMPTY_BYTE;

  // Interrupt conditions and status.
  wire [9:0] wtm_ext = {1'b0, wtm_ff};
  wire fwm_cond = q_enable && 10'(q_count) >= wtm_ext;
  wire latch_on = irq_setup_ff[IS_LATCH];
  wire fwm_set = irq_setup_ff[IS_FWM_EN] && fwm_cond;
  wire full_set = irq_setup_ff[IS_FULL_EN] && q_full;
  wire drdy_set = irq_setup_ff[IS_DRDY_EN] && meas_done;
  // A set arriving with the clear of a read still lands in the flag.
  wire nxt_fwm = fwm_set || (latch_on && status_ff[ST_FWM] && !rd_status);
  wire nxt_full = full_set || (latch_on && status_ff[ST_FULL] && !rd_status);
  wire nxt_drdy = drdy_set || (status_ff[ST_DRDY] && !rd_status);
  wire [7:0] nxt_status = {4'h0, nxt_drdy, 1'b0, nxt_full, nxt_fwm};
  wire irq_active = nxt_fwm || nxt_full || nxt_drdy;
  wire pin_level = irq_setup_ff[IS_ACT_HIGH] ? irq_active : !irq_active;
  // Open-drain only ever pulls low; a high level is left to the pull-up.
  wire nxt_oe_n = irq_setup_ff[IS_OPEN_DRAIN] ? pin_level : 1'b0;
  wire nxt_pin = irq_setup_ff[IS_OPEN_DRAIN] ? 1'b0 : pin_level;

  // Read data selection.
  wire [7:0] rd_mux =
    ({8{reg_addr == ADDR_IRQ_STATUS}} & status_ff) |
    ({8{reg_addr == ADDR_LEVEL_LO}} & q_count[7:0]) |
    ({8{reg_addr == ADDR_LEVEL_HI}} & 8'(q_count[AW:8])) |
    ({8{reg_addr == ADDR_READ_PORT}} & port_byte) |
    ({8{reg_addr == ADDR_WTM_LO}} & wtm_ff[7:0]) |
    ({8{reg_addr == ADDR_WTM_HI}} & {7'h00, wtm_ff[8]}) |
    ({8{reg_addr == ADDR_CONTENT}} & content_ff) |
    ({8{reg_addr == ADDR_SAMPLING}} & sampling_ff) |
    ({8{reg_addr == ADDR_IRQ_SETUP}} & irq_setup_ff) |
    ({8{reg_addr == ADDR_SERIAL}} & serial_ff) |
    ({8{reg_addr == ADDR_POWER}} & power_ff) |
    ({8{reg_addr == ADDR_OVERSAMPLE}} & oversample_ff);

  // Measurement mode decode.
  wire [1:0] mode_code = power_ff[PW_MODE_LSB +: 2];
  wire meas_mode_t nxt_mode = mode_code == 2'h0 ? MODE_SLEEP
                            : mode_code == 2'h3 ? MODE_NORMAL : MODE_FORCED;

  // Watchdog on prolonged serial activity (i2c_busy held high).
  wire wdt_run = serial_ff[SP_WDT_EN] && i2c_busy;
  wire [21:0] wdt_limit = serial_ff[SP_WDT_LONG] ? 22'(WDT_LONG_CYCLES - 1)
                                                 : 22'(WDT_SHORT_CYCLES - 1);
  wire wdt_hit = wdt_run && wdt_cnt_ff >= wdt_limit;

  byte_queue #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_queue (
    .clk(clk),
    .rst_n(rst_n),
    .push(q_push),
    .push_data(frame_ff[7:0]),
    .pop(q_pop),
    .head(q_head),
    .count(q_count),
    .full(q_full),
    .empty(q_empty)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wtm_ff <= 9'h000;
      content_ff <= REG_RESET;
      sampling_ff <= REG_RESET;
      irq_setup_ff <= REG_RESET;
      power_ff <= REG_RESET;
      oversample_ff <= REG_RESET;
    end else begin
      if (wr_wtm_lo) begin
        wtm_ff[7:0] <= reg_wdata;
      end
      if (wr_wtm_hi) begin
        wtm_ff[8] <= reg_wdata[0] & MASK_WTM_HI[0];
      end
      content_ff <= wr_content ? reg_wdata & MASK_CONTENT : content_ff;
      sampling_ff <= wr_sampling ? reg_wdata & MASK_SAMPLING : sampling_ff;
      irq_setup_ff <= wr_irq ? reg_wdata & MASK_IRQ_SETUP : irq_setup_ff;
      power_ff <= wr_power ? reg_wdata & MASK_POWER : power_ff;
      oversample_ff <= wr_osr ? reg_wdata & MASK_OVERSAMPLE : oversample_ff;
    end
  end

  // Watchdog settings come from non-volatile storage on the first edge after reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_ff <= REG_RESET;
      nvm_loaded_ff <= 1'b0;
    end else begin
      nvm_loaded_ff <= 1'b1;
      if (!nvm_loaded_ff) begin
        serial_ff <= {5'h00, nvm_wdt_long, nvm_wdt_en, 1'b0};
      end else if (wr_serial) begin
        serial_ff <= reg_wdata & MASK_SERIAL;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_cnt_ff <= 7'h00;
      frame_ff <= '0;
      frame_left_ff <= 3'h0;
    end else begin
      sub_cnt_ff <= (meas_done && q_enable) ? sub_cnt_ff + 7'h01 : sub_cnt_ff;
      if (store_ev) begin
        frame_ff <= frame_new;
        frame_left_ff <= len_new;
      end else if (blocked || !q_enable) begin
        frame_left_ff <= 3'h0;
      end else if (q_push) begin
        frame_ff <= {8'h00, frame_ff[55:8]};
        frame_left_ff <= frame_left_ff - 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      time_idx_ff <= 3'h0;
      time_snap_ff <= 24'h000000;
    end else begin
      if (!q_empty) begin
        time_idx_ff <= 3'h0;
      end else if (rd_port && time_phase) begin
        time_idx_ff <= time_idx_ff + 3'h1;
      end
      if (rd_port && time_phase && time_idx_ff == 3'h1) begin
        time_snap_ff <= sensor_time;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
      status_ff <= 8'h00;
      int_pin_out_ff <= 1'b1;
      int_pin_oe_n_ff <= 1'b0;
      meas_mode_ff <= MODE_SLEEP;
    end else begin
      reg_rdata_ff <= reg_rd ? rd_mux : reg_rdata_ff;
      status_ff <= nxt_status;
      int_pin_out_ff <= nxt_pin;
      int_pin_oe_n_ff <= nxt_oe_n;
      meas_mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_ff <= 22'h000000;
      i2c_wdt_expire_ff <= 1'b0;
    end else begin
      wdt_cnt_ff <= (!wdt_run || wdt_hit) ? 22'h000000 : wdt_cnt_ff + 22'h000001;
      i2c_wdt_expire_ff <= wdt_hit;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign press_meas_en = power_ff[PW_PRESS];
  assign temp_meas_en = power_ff[PW_TEMP];
  assign meas_mode = meas_mode_ff;
  assign press_oversample_ratio = oversample_ff[OS_PRESS_LSB +: 3];
  assign temperature_oversample_ratio = oversample_ff[OS_TEMP_LSB +: 3];
  assign three_wire_serial_select = serial_ff[SP_THREE_WIRE];
  assign i2c_wdt_enable = serial_ff[SP_WDT_EN];
  assign i2c_wdt_long = serial_ff[SP_WDT_LONG];
  assign i2c_wdt_expire = i2c_wdt_expire_ff;
  assign int_pin_out = int_pin_out_ff;
  assign int_pin_oe_n = int_pin_oe_n_ff;

  chk_level_read: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_LEVEL_LO |=> reg_rdata == $past(q_count[7:0]))
    else $error("level low byte read wrong");
  chk_port_pop: assert property (@(posedge clk) disable iff (!rst_n)
    rd_port && !q_empty && !q_push |=> reg_rdata == $past(q_head) &&
    q_count == $past(q_count) - 10'h001)
    else $error("read port did not pop head");
  chk_wtm_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_wtm_hi ##1 !wr_wtm_hi ##1 reg_rd && reg_addr == ADDR_WTM_HI |=>
    reg_rdata == {7'h00, $past(reg_wdata[0], 3)})
    else $error("watermark high bit lost");
  chk_disabled_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !q_enable && $stable(q_enable) |=> $stable(q_count) || q_count < $past(q_count))
    else $error("queue grew while disabled");
  chk_stop_full: assert property (@(posedge clk) disable iff (!rst_n)
    q_full && stop_full && !rd_port |=> q_full && frame_left_ff == 3'h0)
    else $error("stop on full did not halt");
  chk_time_frame: assert property (@(posedge clk) disable iff (!rst_n)
    rd_port && q_empty && time_en && time_idx_ff == 3'h0 |=> reg_rdata == HDR_TIME)
    else $error("time frame header missing");
  chk_irq_pin: assert property (@(posedge clk) disable iff (!rst_n)
    !irq_setup_ff[IS_OPEN_DRAIN] && irq_setup_ff[IS_ACT_HIGH] && $stable(irq_setup_ff)
    |=> !int_pin_oe_n && int_pin_out == (status_ff != 8'h00))
    else $error("interrupt pin level wrong");
  chk_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status && !latch_on && !meas_done ##1 !meas_done && !fwm_cond && !q_full |=>
    status_ff == 8'h00)
    else $error("status not cleared by read");
  chk_wdt_short: assert property (@(posedge clk) disable iff (!rst_n)
    wdt_run && !serial_ff[SP_WDT_LONG] |-> wdt_cnt_ff < 22'(WDT_SHORT_CYCLES))
    else $error("short watchdog overran");
  chk_mode_map: assert property (@(posedge clk) disable iff (!rst_n)
    wr_power && reg_wdata[PW_MODE_LSB +: 2] == 2'h3 ##1 !wr_power |=>
    meas_mode == MODE_NORMAL)
    else $error("normal mode not selected");
endmodule

// file: sensor_regs_pkg.sv
// Register map, field positions and timing constants of the sensor configuration block.
package sensor_regs_pkg;
  // Register addresses on the internal register port.
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h11;
  localparam logic [7:0] ADDR_LEVEL_LO = 8'h12;
  localparam logic [7:0] ADDR_LEVEL_HI = 8'h13;
  localparam logic [7:0] ADDR_READ_PORT = 8'h14;
  localparam logic [7:0] ADDR_WTM_LO = 8'h15;
  localparam logic [7:0] ADDR_WTM_HI = 8'h16;
  localparam logic [7:0] ADDR_CONTENT = 8'h17;
  localparam logic [7:0] ADDR_SAMPLING = 8'h18;
  localparam logic [7:0] ADDR_IRQ_SETUP = 8'h19;
  localparam logic [7:0] ADDR_SERIAL = 8'h1a;
  localparam logic [7:0] ADDR_POWER = 8'h1b;
  localparam logic [7:0] ADDR_OVERSAMPLE = 8'h1c;
  // Writable bits of each register; everything else reads as zero.
  localparam logic [7:0] MASK_WTM_HI = 8'h01;
  localparam logic [7:0] MASK_CONTENT = 8'h1f;
  localparam logic [7:0] MASK_SAMPLING = 8'h1f;
  localparam logic [7:0] MASK_IRQ_SETUP = 8'h7f;
  localparam logic [7:0] MASK_SERIAL = 8'h07;
  localparam logic [7:0] MASK_POWER = 8'h33;
  localparam logic [7:0] MASK_OVERSAMPLE = 8'h3f;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions.
  localparam int CT_ENABLE = 0;
  localparam int CT_STOP_FULL = 1;
  localparam int CT_TIME_EN = 2;
  localparam int CT_PRESS_EN = 3;
  localparam int CT_TEMP_EN = 4;
  localparam int SS_SUB_LSB = 0;
  localparam int SS_SRC_LSB = 3;
  localparam logic [1:0] SRC_FILTERED = 2'h1;
  localparam int IS_OPEN_DRAIN = 0;
  localparam int IS_ACT_HIGH = 1;
  localparam int IS_LATCH = 2;
  localparam int IS_FWM_EN = 3;
  localparam int IS_FULL_EN = 4;
  localparam int IS_DRDY_EN = 6;
  localparam int SP_THREE_WIRE = 0;
  localparam int SP_WDT_EN = 1;
  localparam int SP_WDT_LONG = 2;
  localparam int PW_PRESS = 0;
  localparam int PW_TEMP = 1;
  localparam int PW_MODE_LSB = 4;
  localparam int OS_PRESS_LSB = 0;
  localparam int OS_TEMP_LSB = 3;
  localparam int ST_FWM = 0;
  localparam int ST_FULL = 1;
  localparam int ST_DRDY = 3;
  // Queue frame bytes.
  localparam logic [7:0] HDR_DATA = 8'h80;
  localparam logic [7:0] HDR_CONTENT_MASK = 8'h18;
  localparam logic [7:0] HDR_TIME = 8'ha0;
  localparam logic [7:0] EMPTY_BYTE = 8'h80;
  localparam logic [2:0] TIME_FRAME_LEN = 3'h4;
  localparam int QUEUE_DEPTH = 512;
  // Watchdog periods.
  localparam int CLK_PERIOD_NS = 20;
  localparam int WDT_SHORT_NS = 1250000;
  localparam int WDT_LONG_NS = 40000000;
  localparam int WDT_SHORT_CYC = WDT_SHORT_NS / CLK_PERIOD_NS;
  localparam int WDT_LONG_CYC = WDT_LONG_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'b001,
    MODE_FORCED = 3'b010,
    MODE_NORMAL = 3'b100
  } meas_mode_t;
endpackage

// file: testbench.sv
// Self-checking bench for the sensor configuration and queue registers.
`timescale 1ns/1ps
module testbench;
  import sensor_regs_pkg::*;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, i2c_busy = 0, fire = 0;
  logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata;
  logic [23:0] base = 24'h0, pu, pf, tu, tf, st;
  logic meas_done, pme, tme, tws, wen, wlong, wexp, int_pin_out, int_pin_oe_n;
  logic [2:0] por, tor;
  meas_mode_t meas_mode;
  int n_mismatch = 0, compares = 0, cyc = 0;
  meas_source i_meas_source (.clk(clk), .fire(fire), .base(base), .meas_done(meas_done),
    .press_unfilt(pu), .press_filt(pf), .temp_unfilt(tu), .temp_filt(tf), .sensor_time(st));
  sensor_cfg_regs #(.WDT_SHORT_CYCLES(8), .WDT_LONG_CYCLES(20)) i_sensor_cfg_regs (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .meas_done(meas_done),
    .press_unfilt(pu), .press_filt(pf), .temp_unfilt(tu), .temp_filt(tf),
    .sensor_time(st), .nvm_wdt_en(1'b0), .nvm_wdt_long(1'b0), .i2c_busy(i2c_busy),
    .press_meas_en(pme), .temp_meas_en(tme), .meas_mode(meas_mode),
    .press_oversample_ratio(por), .temperature_oversample_ratio(tor),
    .three_wire_serial_select(tws), .i2c_wdt_enable(wen), .i2c_wdt_long(wlong),
    .i2c_wdt_expire(wexp), .int_pin_out(int_pin_out), .int_pin_oe_n(int_pin_oe_n));
  always #10 clk = ~clk;
  task automatic print_verdict;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge clk);
    #1 reg_wr = 0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 reg_addr = a;
    reg_rd = 1;
    @(posedge clk);
    #1 reg_rd = 0;
    chk(reg_rdata, exp);
  endtask
  task automatic shot;
    @(posedge clk);
    #1 fire = 1;
    @(posedge clk);
    #1 fire = 0;
    repeat (12) @(posedge clk);
    #1;
  endtask
  // Reset values, writable masks, a read-only and an unmapped place.
  task automatic t_regs;
    logic [7:0] ad [8] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c};
    logic [7:0] mk [8] = '{8'hff, 8'h01, 8'h1f, 8'h1f, 8'h7f, 8'h07, 8'h33, 8'h3f};
    for (int i = 0; i < 8; i++) begin
      rc(ad[i], 8'h00);
      wr(ad[i], 8'hff);
      rc(ad[i], mk[i]);
      wr(ad[i], 8'h00);
    end
    wr(8'h12, 8'hff);
    rc(8'h12, 8'h00);
    rc(8'h20, 8'h00);
  endtask
  // Control fields reach their outputs.
  task automatic t_ctrl;
    logic [2:0] me [4] = '{3'b001, 3'b010, 3'b010, 3'b100};
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_POWER, 8'(m << 4) | 8'h01);
      @(posedge clk);
      #1 chk(meas_mode, me[m]);
      chk({pme, tme}, 2'b10);
    end
    wr(ADDR_POWER, 8'h02);
    wr(ADDR_OVERSAMPLE, 8'h2c);
    wr(ADDR_SERIAL, 8'h01);
    @(posedge clk);
    #1 chk({pme, tme}, 2'b01);
    chk({tor, por}, 6'h2c);
    chk({tws, wen, wlong}, 3'b100);
  endtask
  // One frame per source code 0 to 2, read back byte by byte, then the time frame header.
  task automatic t_queue(input logic [1:0] src);
    logic [23:0] p, t;
    base = 24'h123456 + 24'(src);
    p = (src == 2'h1) ? ~base : base;
    t = (src == 2'h1) ? ~(base + 24'h1) : base + 24'h1;
    wr(ADDR_SAMPLING, 8'(src) << 3);
    wr(ADDR_CONTENT, 8'h1d);
    shot();
    rc(ADDR_LEVEL_LO, 8'h07);
    rc(ADDR_LEVEL_HI, 8'h00);
    rc(ADDR_READ_PORT, 8'h98);
    for (int b = 0; b < 3; b++) rc(ADDR_READ_PORT, p[8*b +: 8]);
    for (int b = 0; b < 3; b++) rc(ADDR_READ_PORT, t[8*b +: 8]);
    rc(ADDR_LEVEL_LO, 8'h00);
    rc(ADDR_READ_PORT, HDR_TIME);
  endtask
  // Pressure only, then queue disabled, then the watermark on the kept bytes, unlatched and latched.
  task automatic t_fill;
    wr(ADDR_CONTENT, 8'h09);
    shot();
    rc(ADDR_LEVEL_LO, 8'h04);
    wr(ADDR_CONTENT, 8'h18);
    shot();
    rc(ADDR_LEVEL_LO, 8'h04);
    rc(ADDR_IRQ_STATUS, 8'h00);
    wr(ADDR_CONTENT, 8'h09);
    wr(ADDR_WTM_LO, 8'h04);
    wr(ADDR_IRQ_SETUP, 8'h08);
    repeat (2) @(posedge clk);
    rc(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_WTM_LO, 8'h05);
    repeat (2) @(posedge clk);
    rc(ADDR_IRQ_STATUS, 8'h00);
    wr(ADDR_WTM_LO, 8'h04);
    wr(ADDR_IRQ_SETUP, 8'h0c);
    wr(ADDR_WTM_LO, 8'h05);
    rc(ADDR_IRQ_STATUS, 8'h01);
    rc(ADDR_IRQ_STATUS, 8'h00);
  endtask
  // Data-ready on the pin in push-pull active low, then the idle pin in each drive type and level.
  task automatic t_irq;
    wr(ADDR_IRQ_SETUP, 8'h40);
    shot();
    chk({int_pin_out, int_pin_oe_n}, 2'b00);
    rc(ADDR_IRQ_STATUS, 8'h08);
    rc(ADDR_IRQ_STATUS, 8'h00);
    chk({int_pin_out, int_pin_oe_n}, 2'b10);
    wr(ADDR_IRQ_SETUP, 8'h42);
    repeat (2) @(posedge clk);
    #1 chk({int_pin_out, int_pin_oe_n}, 2'b00);
    wr(ADDR_IRQ_SETUP, 8'h41);
    repeat (2) @(posedge clk);
    #1 chk({int_pin_out, int_pin_oe_n}, 2'b01);
    wr(ADDR_IRQ_SETUP, 8'h43);
    repeat (2) @(posedge clk);
    #1 chk({int_pin_out, int_pin_oe_n}, 2'b00);
  endtask
  // Stop-on-full keeps the oldest bytes; subsampling by two keeps one of two conversions.
  task automatic t_full;
    wr(ADDR_SAMPLING, 8'h01);
    wr(ADDR_CONTENT, 8'h0b);
    wr(ADDR_IRQ_SETUP, 8'h10);
    repeat (2) shot();
    rc(ADDR_LEVEL_LO, 8'h0c);
    wr(ADDR_SAMPLING, 8'h00);
    repeat (126) shot();
    rc(ADDR_LEVEL_HI, 8'h02);
    rc(ADDR_LEVEL_LO, 8'h00);
    rc(ADDR_IRQ_STATUS, 8'h02);
    rc(ADDR_READ_PORT, 8'h88);
    rc(ADDR_LEVEL_LO, 8'hff);
  endtask
  // Watchdog stays quiet while disabled, then expires after the scaled short and long limits.
  task automatic t_wdt;
    logic [7:0] sv [3] = '{8'h00, 8'h02, 8'h06};
    int lo [3] = '{40, 7, 19};
    int hi [3] = '{40, 10, 22};
    int n;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_SERIAL, sv[i]);
      @(posedge clk);
      #1 chk({wlong, wen}, sv[i][2:1]);
      i2c_busy = 1;
      n = 0;
      while (wexp !== 1'b1 && n < 40) begin
        @(posedge clk);
        #1 n++;
      end
      chk(n >= lo[i] && n <= hi[i], 1'b1);
      i2c_busy = 0;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    repeat (2) @(posedge clk);
    t_regs();
    t_ctrl();
    for (int s = 0; s < 3; s++) t_queue(2'(s));
    t_fill();
    t_irq();
    t_full();
    t_wdt();
    print_verdict();
  end
endmodule
